// file: design/sdc_flag_bank.sv
// Bank of sticky flags, set by hardware, cleared by a strobe.
// Assumes set and clear strobes are one-cycle and synchronous.
`timescale 1ns/10ps
module sdc_flag_bank
  import sdc_pkg::*;
#(
  parameter int N = N_FLAGS
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] flags_o
);

  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      // Set wins over a clear in the same cycle
      always_comb begin
        flag_next[g] = set_i[g] | (flag_reg[g] & ~clr_i[g]);
      end
    end
  endgenerate

  // Flag storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flags_o = flag_reg;

endmodule

// file: design/sdc_pkg.sv
// Shared constants and types for the converter status block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package sdc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_ENCLR  = 6'h04;
  localparam logic [5:0] IDX_ENSET  = 6'h05;
  localparam logic [5:0] IDX_FLAG   = 6'h06;
  localparam logic [5:0] IDX_SEQ    = 6'h08;
  localparam logic [5:0] IDX_CHSEL  = 6'h09;
  localparam logic [5:0] IDX_RESULT = 6'h0C;

  // Flag and enable bit positions
  localparam int N_FLAGS     = 4;
  localparam int FLG_RESULT_AVAIL = 0;
  localparam int FLG_OVERRUN      = 1;
  localparam int FLG_WINDOW       = 2;
  localparam int FLG_COUNT_WRAP   = 3;

  // Sequence status layout
  localparam int SEQ_BUSY_BIT = 7;
  localparam int SEQ_PTR_W    = 4;

  // Reset values
  localparam logic [N_FLAGS-1:0]   ENABLE_RST = 4'h0;
  localparam logic [N_FLAGS-1:0]   FLAG_RST   = 4'h0;
  localparam logic [7:0]           CHSEL_RST  = 8'h00;
  localparam logic [SEQ_PTR_W-1:0] SEQ_PTR_RST = 4'h0;

  // Events from the conversion core
  typedef struct packed {
    logic                 result_valid;
    logic [15:0]          result;
    logic                 seq_start;
    logic                 seq_last;
    logic [SEQ_PTR_W-1:0] seq_index;
    logic                 window_hit;
    logic                 count_wrap;
  } sdc_core_evt_t;

  // Sequence tracker states
  typedef enum logic {SEQ_IDLE, SEQ_RUN} sdc_seq_state_t;

  // Word address match against a register index
  function automatic logic sdc_hit(input logic [7:0] adr, input logic [5:0] idx);
    return adr == {idx, 2'b00};
  endfunction

endpackage

// file: design/sdc_seq_track.sv
// Sequence busy bit and last-completed conversion pointer.
// Assumes start and done strobes are one-cycle pulses from the core.
`timescale 1ns/10ps
module sdc_seq_track
  import sdc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 start_i,
  input  wire logic                 done_i,
  input  wire logic                 last_i,
  input  wire logic [SEQ_PTR_W-1:0] index_i,
  output logic                      busy_o,
  output logic      [SEQ_PTR_W-1:0] ptr_o
);

  sdc_seq_state_t       state_reg;
  sdc_seq_state_t       state_next;
  logic [SEQ_PTR_W-1:0] ptr_reg;
  logic [SEQ_PTR_W-1:0] ptr_next;

  // Busy from start until the final conversion; a new start wins
  always_comb begin
    state_next = state_reg;
    ptr_next   = ptr_reg;
    if (done_i) begin
      ptr_next = index_i;
    end
    case (state_reg)
      SEQ_IDLE: begin
        if (start_i) begin
          state_next = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (done_i && last_i && !start_i) begin
          state_next = SEQ_IDLE;
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= SEQ_IDLE;
      ptr_reg   <= SEQ_PTR_RST;
    end else begin
      state_reg <= state_next;
      ptr_reg   <= ptr_next;
    end
  end

  assign busy_o = (state_reg == SEQ_RUN);
  assign ptr_o  = ptr_reg;

endmodule

// file: design/sdc_status_top.sv
// Result flags, interrupt enables and sequence status of a converter.
// Assumes a classic Wishbone master on CLOCK_I and core event pulses.
//
// Function
// - New result while unread sets overrun flag
// - Write one clears overrun; zero leaves it
// - Result arrival sets result-available flag
// - Write one or result read clears it
// - Overrun and ready interrupt when flag and enable
// - Busy bit 7 set on start, cleared at last
// - Pointer bits 3:0 show last completed conversion
// - Enable clear register, write one clears enable
// - Window and overflow requests need set enable
`timescale 1ns/10ps
module sdc_status_top
  import sdc_pkg::*;
#(
  parameter int RES_W = 16
) (
  input  wire logic          CLOCK_I,
  input  wire logic          RST_I,
  input  wire logic          CYC_I,
  input  wire logic          STB_I,
  input  wire logic          WE_I,
  input  wire logic [7:0]    ADR_I,
  input  wire logic [3:0]    SEL_I,
  input  wire logic [31:0]   DAT_I,
  output logic      [31:0]   DAT_O,
  output logic               ACK_O,
  input  wire sdc_core_evt_t CORE_EVT_I,
  output logic      [7:0]    CHANNEL_SEL_O,
  output logic               IRQ_O
);

  // Bus handshake state
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;

  // Access strobes, valid at the edge where the master sees ack
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic lane0;

  // Register write strobes and the result read strobe
  logic wr_enclr;
  logic wr_enset;
  logic wr_flag;
  logic wr_chsel;
  logic rd_result;

  // Software-visible storage
  logic [N_FLAGS-1:0] enable_reg;
  logic [N_FLAGS-1:0] enable_next;
  logic [7:0]         chsel_reg;
  logic [7:0]         chsel_next;
  logic [RES_W-1:0]   result_reg;
  logic [RES_W-1:0]   result_next;
  logic               irq_reg;
  logic               irq_next;

  // Flag bank connections
  logic [N_FLAGS-1:0] flag_set;
  logic [N_FLAGS-1:0] flag_clr;
  logic [N_FLAGS-1:0] flags;
  logic [N_FLAGS-1:0] flags_after;

  // Sequence tracker connections
  logic                 seq_busy;
  logic [SEQ_PTR_W-1:0] seq_ptr;
  logic [7:0]           seq_status;

  // Bus access decode
  always_comb begin
    acc       = CYC_I & STB_I & ack_reg;
    wr_acc    = acc & WE_I;
    rd_acc    = acc & ~WE_I;
    lane0     = SEL_I[0];
    wr_enclr  = wr_acc & lane0 & sdc_hit(ADR_I, IDX_ENCLR);
    wr_enset  = wr_acc & lane0 & sdc_hit(ADR_I, IDX_ENSET);
    wr_flag   = wr_acc & lane0 & sdc_hit(ADR_I, IDX_FLAG);
    wr_chsel  = wr_acc & lane0 & sdc_hit(ADR_I, IDX_CHSEL);
    rd_result = rd_acc & sdc_hit(ADR_I, IDX_RESULT);
  end

  // Ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_next = CYC_I & STB_I & ~ack_reg;
  end

  // Read data is captured together with ack
  always_comb begin
    dat_next = 32'h0000_0000;
    if (CYC_I && STB_I && !ack_reg && !WE_I) begin
      if (sdc_hit(ADR_I, IDX_ENCLR) || sdc_hit(ADR_I, IDX_ENSET)) begin
        dat_next[N_FLAGS-1:0] = enable_reg;
      end else if (sdc_hit(ADR_I, IDX_FLAG)) begin
        dat_next[N_FLAGS-1:0] = flags;
      end else if (sdc_hit(ADR_I, IDX_SEQ)) begin
        dat_next[7:0] = seq_status;
      end else if (sdc_hit(ADR_I, IDX_CHSEL)) begin
        dat_next[7:0] = chsel_reg;
      end else if (sdc_hit(ADR_I, IDX_RESULT)) begin
        dat_next[RES_W-1:0] = result_reg;
      end else begin
        dat_next = 32'h0000_0000;
      end
    end
  end

  // Bus registers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // Interrupt enables: set and clear views of one register
  always_comb begin
    enable_next = enable_reg;
    if (wr_enset) begin
      enable_next = enable_reg | DAT_I[N_FLAGS-1:0];
    end
    if (wr_enclr) begin
      enable_next = enable_reg & ~DAT_I[N_FLAGS-1:0];
    end
  end

  // Channel select and result holding register
  always_comb begin
    chsel_next  = chsel_reg;
    result_next = result_reg;
    if (wr_chsel) begin
      chsel_next = DAT_I[7:0];
    end
    if (CORE_EVT_I.result_valid) begin
      result_next = CORE_EVT_I.result[RES_W-1:0];
    end
  end

  // Flag set sources from the core
  always_comb begin
    flag_set              = '0;
    flag_set[FLG_RESULT_AVAIL] = CORE_EVT_I.result_valid;
    flag_set[FLG_OVERRUN]      = CORE_EVT_I.result_valid & flags[FLG_RESULT_AVAIL] &
                                 ~rd_result;
    flag_set[FLG_WINDOW]       = CORE_EVT_I.window_hit;
    flag_set[FLG_COUNT_WRAP]   = CORE_EVT_I.count_wrap;
  end

  // Flag clears: write one, or result read for ready
  always_comb begin
    flag_clr = '0;
    if (wr_flag) begin
      flag_clr = DAT_I[N_FLAGS-1:0];
    end
    if (rd_result) begin
      flag_clr[FLG_RESULT_AVAIL] = 1'b1;
    end
  end

  // Sticky interrupt flags
  sdc_flag_bank #(
    .N (N_FLAGS)
  ) u_flags (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .set_i   (flag_set),
    .clr_i   (flag_clr),
    .flags_o (flags)
  );

  // Sequence busy and pointer
  sdc_seq_track u_seq (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .start_i (CORE_EVT_I.seq_start),
    .done_i  (CORE_EVT_I.result_valid),
    .last_i  (CORE_EVT_I.seq_last),
    .index_i (CORE_EVT_I.seq_index),
    .busy_o  (seq_busy),
    .ptr_o   (seq_ptr)
  );

  // Status byte: busy on top, pointer at the bottom
  always_comb begin
    seq_status                  = 8'h00;
    seq_status[SEQ_BUSY_BIT]    = seq_busy;
    seq_status[SEQ_PTR_W-1:0]   = seq_ptr;
  end

  // Interrupt from the flag and enable values of the next cycle
  always_comb begin
    flags_after = flag_set | (flags & ~flag_clr);
    irq_next    = |(flags_after & enable_next);
  end

  // Control registers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      enable_reg <= ENABLE_RST;
      chsel_reg  <= CHSEL_RST;
      result_reg <= '0;
      irq_reg    <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      chsel_reg  <= chsel_next;
      result_reg <= result_next;
      irq_reg    <= irq_next;
    end
  end

  assign ACK_O         = ack_reg;
  assign DAT_O         = dat_reg;
  assign CHANNEL_SEL_O = chsel_reg;
  assign IRQ_O         = irq_reg;

endmodule

// file: tb/sdc_status_checker.sv
// Port checker for the converter status block.
// Assumes it is bound to sdc_status_top and sees only its ports.
`timescale 1ns/10ps
module sdc_status_checker
  import sdc_pkg::*;
(
  input wire logic          CLOCK_I,
  input wire logic          RST_I,
  input wire logic          CYC_I,
  input wire logic          STB_I,
  input wire logic          WE_I,
  input wire logic [7:0]    ADR_I,
  input wire logic [31:0]   DAT_O,
  input wire logic          ACK_O,
  input wire sdc_core_evt_t CORE_EVT_I,
  input wire logic [7:0]    CHANNEL_SEL_O,
  input wire logic          IRQ_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  // Bus timing
  chk_ack_delay: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack late");
  chk_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack held");
  chk_idle_data: assert property (!ACK_O || WE_I |-> DAT_O == 32'h0)
    else $error("read data outside read ack");

  // Read layouts of status and enable words
  chk_seq_layout: assert property (
    ACK_O && ADR_I == {IDX_SEQ, 2'b00} |-> DAT_O[31:8] == 0 && DAT_O[6:4] == 0)
    else $error("sequence word has stray bits");
  chk_flag_layout: assert property (
    ACK_O && ADR_I[7:4] == 4'h1 |-> DAT_O[31:4] == 28'h0)
    else $error("flag or enable word has stray bits");

  // Interrupt and register changes need a cause
  chk_irq_fall: assert property ($fell(IRQ_O) |-> $past(ACK_O))
    else $error("interrupt dropped without access");
  chk_irq_rise: assert property ($rose(IRQ_O) |-> $past(ACK_O && WE_I ||
    CORE_EVT_I.result_valid || CORE_EVT_I.window_hit || CORE_EVT_I.count_wrap))
    else $error("interrupt rose without cause");
  chk_chsel_hold: assert property (!$stable(CHANNEL_SEL_O) |-> $past(ACK_O && WE_I))
    else $error("channel select changed without write");
endmodule

bind sdc_status_top sdc_status_checker sdc_status_checker_inst (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .CORE_EVT_I(CORE_EVT_I),
  .CHANNEL_SEL_O(CHANNEL_SEL_O), .IRQ_O(IRQ_O));

// file: tb/tb_sdc_status_top.sv
// Self-checking bench for the converter status block.
// Assumes the port checker is bound in from its own file.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t got %0h want %0h", $time, a, b); end end
module tb_sdc_status_top;
  import sdc_pkg::*;
  logic          clock, rst, cyc, stb, we, ack, irq;
  logic [7:0]    adr, chsel, c8;
  logic [3:0]    sel, p;
  logic [31:0]   wdat, rdat, exp_v;
  logic [31:0]   exp_q[$];
  logic [15:0]   r;
  sdc_core_evt_t evt;
  int            errors, n_checks, seed, i;

  sdc_status_top #(.RES_W(16)) sdc_status_top_inst (
    .CLOCK_I(clock), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .CORE_EVT_I(evt), .CHANNEL_SEL_O(chsel), .IRQ_O(irq));

  // Clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [5:0] ix, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    sel <= s;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    wb(1'b1, ix, {24'h0, d}, 4'h1);
  endtask

  // Note the expected word, then read
  task automatic rd(input logic [5:0] ix, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, ix, 32'h0, 4'hF);
  endtask

  // One-cycle core event
  task automatic ev(input logic v, input logic s, input logic l, input logic [3:0] x,
                    input logic w, input logic c);
    @(posedge clock);
    evt <= '{v, r, s, l, x, w, c};
    @(posedge clock);
    evt <= '0;
  endtask

  task automatic ck_irq(input logic e);
    @(negedge clock);
    `CHK(irq, e)
  endtask

  // Read data watcher
  always @(posedge clock) begin
    if (ack === 1'b1 && we === 1'b0) begin
      exp_v = exp_q.pop_front();
      `CHK(rdat, exp_v)
    end
  end

  // Main sequence
  initial begin
    {rst, cyc, stb, we, adr, sel, wdat, evt} = '0;
    rst = 1'b1;
    errors = 0;
    n_checks = 0;
    seed = 32'h3f8b013e;
    r = 16'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(IDX_FLAG, 32'h0);
    rd(IDX_ENCLR, 32'h0);
    rd(IDX_SEQ, 32'h0);
    rd(6'h0F, 32'h0);
    c8 = $random(seed);
    wr(IDX_CHSEL, c8);
    wb(1'b1, IDX_CHSEL, {24'h0, ~c8}, 4'hE);
    rd(IDX_CHSEL, {24'h0, c8});
    `CHK(chsel, c8)
    // Second result while unread, then read clear and write clear
    p = $random(seed);
    ev(1'b1, 1'b0, 1'b0, p, 1'b0, 1'b0);
    rd(IDX_FLAG, 32'h1);
    r = $random(seed);
    ev(1'b1, 1'b1, 1'b0, p, 1'b0, 1'b0);
    rd(IDX_FLAG, 32'h3);
    rd(IDX_SEQ, {24'h0, 4'h8, p});
    rd(IDX_RESULT, {16'h0, r});
    rd(IDX_FLAG, 32'h2);
    wr(IDX_FLAG, 8'h0);
    rd(IDX_FLAG, 32'h2);
    wr(IDX_FLAG, 8'h2);
    ev(1'b1, 1'b0, 1'b1, ~p, 1'b0, 1'b0);
    rd(IDX_SEQ, {24'h0, 4'h0, ~p});
    wr(IDX_FLAG, 8'hF);
    // Each interrupt source: raise, then mask
    for (i = 0; i < 4; i++) begin
      wr(IDX_ENSET, 8'h1 << i);
      ev(i < 2, 1'b0, 1'b0, p, i == 2, i == 3);
      if (i == 1) ev(1'b1, 1'b0, 1'b0, p, 1'b0, 1'b0);
      ck_irq(1'b1);
      rd(IDX_ENCLR, 32'h1 << i);
      wr(IDX_ENCLR, 8'h1 << i);
      ck_irq(1'b0);
      wr(IDX_FLAG, 8'hF);
    end
    // New result in the cycle a clear takes effect
    wr(IDX_ENSET, 8'h1);
    fork
      wr(IDX_FLAG, 8'h1);
      ev(1'b0, 1'b0, 1'b0, p, 1'b0, 1'b0);
    join
    fork
      wr(IDX_FLAG, 8'h1);
      begin
        @(posedge clock);
        ev(1'b1, 1'b0, 1'b0, p, 1'b0, 1'b0);
      end
    join
    ck_irq(1'b1);
    rd(IDX_FLAG, 32'h1);
    tally_and_finish();
  end
endmodule
